// >>> src/spg_map.svh
// constants for the scrambled greyscale pwm generator
// assumes mclk runs at 100 MHz; included by bare name
`ifndef SPG_MAP_SVH
`define SPG_MAP_SVH

`define SPG_NUM_CH      12
`define SPG_GS_W        12
`define SPG_GS_RESET    12'h000
`define SPG_MCLK_NS     10
`define SPG_PWM_CLK_NS  100
// mclk cycles per pwm clock, rounded down, at least one
`define SPG_DIV_CNT     ((`SPG_PWM_CLK_NS / `SPG_MCLK_NS) > 0 ? \
                         (`SPG_PWM_CLK_NS / `SPG_MCLK_NS) : 1)
`define SPG_DIV_LAST    4'((`SPG_DIV_CNT) - 1)
`define SPG_CYCLE_LAST  12'hFFF
`define SPG_SUB_LAST    5'h1F
`define SPG_SLOT_FIRST  7'h00
`define SPG_SLOT_LAST   7'h7F
`define SPG_SPREAD_SLOTS 8'h7F

`endif

// >>> src/spg_pkg.sv
// types and shared arithmetic of the scrambled pwm generator
// assumes spg_map.svh is reachable on the include path
`include "spg_map.svh"

package spg_pkg;

	// sequencer states
	typedef enum logic {
		SPG_RUN,
		SPG_STOP
	} spg_state_e;

	// spread accumulator step, modulo the slots that carry sub-periods
	function automatic logic [6:0] spg_acc_step(input logic [6:0] acc,
	                                            input logic [6:0] n);
		logic [7:0] sum;
		sum = {1'b0, acc} + {1'b0, n};
		if (sum >= `SPG_SPREAD_SLOTS) begin
			sum = sum - `SPG_SPREAD_SLOTS;
		end
		spg_acc_step = sum[6:0];
	endfunction

endpackage

// >>> src/spg_chan.sv
// one channel of the scrambled pwm: remainder then spread sub-periods
// assumes a shared pwm position and tick from the sequencer
`timescale 1ns/1ps
`include "spg_map.svh"

module spg_chan
	import spg_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [11:0] gs,
	input  wire logic        tick,
	input  wire logic        restart,
	input  wire logic        run,
	input  wire logic        en,
	input  wire logic [11:0] cnt,
	output logic             out_reg
);

	logic [6:0] acc_reg;  // spread phase for the current slot
	logic [6:0] sub_n;    // count of whole 32-clock sub-periods
	logic [4:0] rem;      // leftover clocks
	logic [6:0] slot;     // 32-clock slot index
	logic [4:0] phase;    // clock inside the slot
	logic       on_next;  // raw channel level for this pwm clock

	assign sub_n = gs[11:5];
	assign rem   = gs[4:0];
	assign slot  = cnt[11:5];
	assign phase = cnt[4:0];

	// slot 0 is kept for the remainder so the two never overlap;
	// the n sub-periods share the other 127 slots evenly
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= 7'h00;
		end else if (restart) begin
			acc_reg <= 7'h00;
		end else if (tick && phase == `SPG_SUB_LAST) begin
			if (slot == `SPG_SLOT_LAST || slot == `SPG_SLOT_FIRST) begin
				acc_reg <= 7'h00;
			end else begin
				acc_reg <= spg_acc_step(acc_reg, sub_n);
			end
		end
	end

	// remainder first, then a sub-period wherever the spread phase is below n
	always_comb begin
		if (slot == `SPG_SLOT_FIRST) begin
			on_next = (phase < rem);
		end else begin
			on_next = (acc_reg < sub_n);
		end
	end

	// registered drive of the current sink
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= run & en & on_next;
		end
	end

endmodule

// >>> src/spg_top.sv
// scrambled greyscale pwm generator for twelve current sinks
// assumes greyscale, load and control bits come from same-clock serial logic;
// the overtemperature level arrives asynchronously
//
// Behaviour
// - on-time split into spread 32-clock sub-periods
// - leftover clocks placed at cycle start
// - pwm clock about 10 MHz, 100 ns
// - cycle 4096 clocks, on-time equals greyscale
// - cycles repeat endlessly unless one-shot, even while disabled
// - new greyscale interrupts and restarts cycle
// - twelve 12-bit greyscale values, zero at reset
// - one-shot runs a single cycle then stops
// - outputs on only when disable and id bit low
// - overtemperature shutdown forces outputs off when enabled
`timescale 1ns/1ps
`include "spg_map.svh"

module spg_top
	import spg_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic [143:0] channel_greyscale_value,
	input  wire logic         gs_load,
	input  wire logic         output_disable_bit,
	input  wire logic         id_bit3,
	input  wire logic         one_shot,
	input  wire logic         ot_shutdown_en,
	input  wire logic         ot_condition,
	output logic [11:0]       current_sink_outputs,
	output logic              pwm_running_reg
);

	logic [143:0]     gs_reg;      // held greyscale of all channels
	logic [3:0]       div_reg;     // mclk divider to the pwm clock
	logic [11:0]      cnt_reg;     // position inside the pwm cycle
	spg_state_e       state_reg;   // running or stopped
	logic             ot_meta_reg; // first synchroniser stage
	logic             ot_sync_reg; // overtemperature, synchronised
	logic             tick;        // one mclk per pwm clock
	logic             run;         // sequencer is running
	logic             en;          // channels allowed on
	logic             cycle_end;   // last pwm clock of a running cycle

	assign tick      = (div_reg == `SPG_DIV_LAST);
	assign run       = (state_reg == SPG_RUN);
	assign cycle_end = run && tick && (cnt_reg == `SPG_CYCLE_LAST);

	// enable needs both disable bits low and no active thermal shutdown
	assign en = ~output_disable_bit & ~id_bit3
	          & ~(ot_shutdown_en & ot_sync_reg);

	// overtemperature level crosses in from the analog side
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ot_meta_reg <= 1'b0;
			ot_sync_reg <= 1'b0;
		end else begin
			ot_meta_reg <= ot_condition;
			ot_sync_reg <= ot_meta_reg;
		end
	end

	// greyscale store, all channels updated together
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gs_reg <= {`SPG_NUM_CH{`SPG_GS_RESET}};
		end else if (gs_load) begin
			gs_reg <= channel_greyscale_value;
		end
	end

	// pwm clock divider; realigned on load so the new cycle is full
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 4'h0;
		end else if (gs_load || tick) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end

	// cycle position; wraps naturally after 4096 pwm clocks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 12'h000;
		end else if (gs_load) begin
			cnt_reg <= 12'h000;
		end else if (run && tick) begin
			cnt_reg <= cnt_reg + 12'h001;
		end
	end

	// sequencer: endless unless one-shot, any load restarts it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= SPG_RUN;
		end else begin
			case (state_reg)
				SPG_RUN: begin
					// one-shot checked at the wrap, so a late change still counts
					if (!gs_load && cycle_end && one_shot) begin
						state_reg <= SPG_STOP;
					end else begin
						state_reg <= SPG_RUN;
					end
				end
				SPG_STOP: begin
					if (gs_load) begin
						state_reg <= SPG_RUN;
					end
				end
				default: begin
					state_reg <= SPG_RUN;
				end
			endcase
		end
	end

	// status flop for the outside
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_running_reg <= 1'b0;
		end else begin
			pwm_running_reg <= (state_reg == SPG_RUN);
		end
	end

	// one slice per channel
	genvar ch;
	generate
		for (ch = 0; ch < `SPG_NUM_CH; ch = ch + 1) begin : g_ch
			spg_chan u_chan (
				.mclk    (mclk),
				.arst_n  (arst_n),
				.gs      (gs_reg[ch*12 +: 12]),
				.tick    (tick),
				.restart (gs_load),
				.run     (run),
				.en      (en),
				.cnt     (cnt_reg),
				.out_reg (current_sink_outputs[ch])
			);
		end
	endgenerate

	// helper: on-clocks of channel 0 over an undisturbed cycle
	logic [12:0] on_cnt_reg;  // pwm clocks seen high so far
	logic        clean_reg;   // no load or disable since cycle start

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt_reg <= 13'h0000;
			clean_reg  <= 1'b1;
		end else if (gs_load) begin
			on_cnt_reg <= 13'h0000;
			clean_reg  <= 1'b1;
		end else if (cycle_end) begin
			on_cnt_reg <= 13'h0000;
			clean_reg  <= en;
		end else begin
			if (run && tick) begin
				on_cnt_reg <= on_cnt_reg + {12'h000, current_sink_outputs[0]};
			end
			if (!en) begin
				clean_reg <= 1'b0;
			end
		end
	end

	// pwm clock is exactly ten mclk periods; a load in between realigns it
	AST_DIV_PERIOD: assert property (@(posedge mclk) disable iff (!arst_n)
		(tick && !gs_load) ##1 (!gs_load [*8]) ##1 !gs_load |-> !tick ##1 tick)
		else $error("pwm clock period is not ten mclk");

	// a full undisturbed cycle carries exactly the greyscale on-time
	AST_ON_COUNT: assert property (@(posedge mclk) disable iff (!arst_n)
		(cycle_end && clean_reg && en && !gs_load)
		|-> (on_cnt_reg + {12'h000, current_sink_outputs[0]}) == {1'b0, gs_reg[11:0]})
		else $error("channel 0 on-time differs from greyscale");

	// remainder clocks sit in the first slot
	AST_REMAINDER: assert property (@(posedge mclk) disable iff (!arst_n)
		(run && en && !gs_load && cnt_reg[11:5] == 7'h00
		 && cnt_reg[4:0] < gs_reg[4:0]) |=> current_sink_outputs[0])
		else $error("remainder not driven at cycle start");

	// first spread slot is always on when sub-periods exist
	AST_SPREAD: assert property (@(posedge mclk) disable iff (!arst_n)
		(run && en && !gs_load && cnt_reg[11:5] == 7'h01 && gs_reg[11:5] != 7'h00)
		|=> current_sink_outputs[0])
		else $error("sub-period missing in first spread slot");

	// zero greyscale stays dark
	AST_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
		(gs_reg[11:0] == 12'h000 && !gs_load) |=> !current_sink_outputs[0])
		else $error("zero greyscale channel pulsed");

	// load restarts the cycle and stores the data
	AST_RESTART: assert property (@(posedge mclk) disable iff (!arst_n)
		gs_load |=> (cnt_reg == 12'h000 && state_reg == SPG_RUN
		             && gs_reg == $past(channel_greyscale_value)))
		else $error("load did not restart with new data");

	// one-shot stops after the wrap and stays stopped
	AST_ONESHOT: assert property (@(posedge mclk) disable iff (!arst_n)
		(cycle_end && one_shot && !gs_load) |=> (state_reg == SPG_STOP) ##1
		(state_reg == SPG_STOP || $past(gs_load)))
		else $error("one-shot did not stop after one cycle");

	// endless mode keeps running across the wrap
	AST_ENDLESS: assert property (@(posedge mclk) disable iff (!arst_n)
		(cycle_end && !one_shot) |=> (state_reg == SPG_RUN && cnt_reg == 12'h000))
		else $error("endless mode did not restart the cycle");

	// disable bits darken every channel
	AST_DISABLE: assert property (@(posedge mclk) disable iff (!arst_n)
		(output_disable_bit || id_bit3) |=> current_sink_outputs == 12'h000)
		else $error("channels lit while disabled");

	// thermal shutdown three cycles after the pin at most
	AST_OT: assert property (@(posedge mclk) disable iff (!arst_n)
		(ot_shutdown_en && ot_condition) [*3] |=> current_sink_outputs == 12'h000)
		else $error("outputs on during overtemperature shutdown");

	COV_ONESHOT: cover property (@(posedge mclk) disable iff (!arst_n)
		cycle_end && one_shot ##1 state_reg == SPG_STOP);
	COV_MIDLOAD: cover property (@(posedge mclk) disable iff (!arst_n)
		run && cnt_reg == 12'h800 && gs_load);
	COV_REM_ON: cover property (@(posedge mclk) disable iff (!arst_n)
		cycle_end && clean_reg && gs_reg[4:0] != 5'h00 && gs_reg[11:5] != 7'h00);

endmodule

// >>> verif/tb.sv
// self-checking bench for the scrambled greyscale pwm generator
// assumes spg_pkg and spg_top from src/ are compiled first; mclk is 100 MHz
`timescale 1ns/1ps

module tb;

	logic         mclk;                     // 100 MHz system clock
	logic         arst_n;                   // async reset, active low
	logic [143:0] channel_greyscale_value;  // twelve packed greyscale words
	logic         gs_load;                  // one-cycle load strobe
	logic         output_disable_bit;       // global off
	logic         id_bit3;                  // identifier bit, also forces off
	logic         one_shot;                 // single cycle mode
	logic         ot_shutdown_en;           // overtemperature shutdown enable
	logic         ot_condition;             // overtemperature level
	logic [11:0]  current_sink_outputs;     // sink enables seen
	logic         pwm_running_reg;          // sequencer running flag
	logic [143:0] gs_exp;                   // greyscale the model follows
	logic [11:0]  exp_v;                    // expected sink pattern this mclk
	logic         chk_en;                   // per-cycle compare gate
	logic         force_off;                // model expects all sinks off
	int           error_cnt;                // mismatches
	int           total_checks;             // comparisons made
	int           cyc;                      // timeout counter
	int           t;                        // mclk edges since last load
	int           on_cnt [12];              // on pwm clocks per channel

	localparam logic [143:0] V1 = {12'hFFF, 12'hFFE, 12'h7FF, 12'h400, 12'h014, 12'h064,
	                              12'h03F, 12'h021, 12'h020, 12'h01F, 12'h001, 12'h000};
	localparam logic [143:0] V2 = {12'h800, 12'h555, 12'hAAA, 12'h123, 12'h000, 12'h0FF,
	                              12'h040, 12'h7E0, 12'h001, 12'hF00, 12'h3C3, 12'h010};

	spg_top u_dut (
		.mclk                    (mclk),
		.arst_n                  (arst_n),
		.channel_greyscale_value (channel_greyscale_value),
		.gs_load                 (gs_load),
		.output_disable_bit      (output_disable_bit),
		.id_bit3                 (id_bit3),
		.one_shot                (one_shot),
		.ot_shutdown_en          (ot_shutdown_en),
		.ot_condition            (ot_condition),
		.current_sink_outputs    (current_sink_outputs),
		.pwm_running_reg         (pwm_running_reg)
	);

	// free-running clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// reference pattern: remainder in slot 0, n sub-periods spread over slots 1..127
	function automatic logic [11:0] exp_out(input logic [143:0] g, input int p);
		int n;
		int r;
		int s;
		for (int c = 0; c < 12; c++) begin
			n = g[12*c+5 +: 7];
			r = g[12*c +: 5];
			s = p / 32;
			exp_out[c] = (s == 0) ? ((p % 32) < r) : ((((s - 1) * n) % 127) < n);
		end
	endfunction

	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// data and strobe together, strobe lowered after the sampling edge
	task automatic load(input logic [143:0] v);
		@(posedge mclk);
		channel_greyscale_value <= v;
		gs_load <= 1'b1;
		@(posedge mclk);
		gs_load <= 1'b0;
	endtask

	// apply {disable, id bit, ot enable, ot level}; skip the settling edges
	task automatic ctl(input logic [3:0] v, input int lat);
		@(posedge mclk);
		{output_disable_bit, id_bit3, ot_shutdown_en, ot_condition} <= v;
		chk_en = 1'b0;
		force_off = v[3] | v[2] | (v[1] & v[0]);
		wait_cyc(lat);
		chk_en = 1'b1;
		wait_cyc(40);
	endtask

	// edge counter since load; model tracks the greyscale taken at that edge
	always @(posedge mclk) begin
		cyc++;
		if (gs_load) begin
			t <= 0;
			gs_exp <= channel_greyscale_value;
		end else begin
			t <= t + 1;
		end
		// ceiling well above the ~86k edges the tests need
		if (cyc == 95000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// compare at the falling edge, once outputs have settled;
	// pwm clock p stands from edge 1+10p to 10+10p after the load edge
	always @(negedge mclk) begin
		if (t == 0) begin
			foreach (on_cnt[c]) on_cnt[c] = 0;
		end
		if (chk_en && t >= 1) begin
			exp_v = force_off ? 12'h000 : exp_out(gs_exp, ((t - 1) / 10) % 4096);
			chk("sinks", exp_v, current_sink_outputs);
			if ((t - 1) % 10 == 0 && t < 40961) begin
				foreach (on_cnt[c]) on_cnt[c] += current_sink_outputs[c];
			end
		end
	end

	initial begin
		{arst_n, gs_load, output_disable_bit, id_bit3} = 4'h0;
		{one_shot, ot_shutdown_en, ot_condition, chk_en, force_off} = 5'h00;
		channel_greyscale_value = 144'h0;
		gs_exp = 144'h0;
		{error_cnt, total_checks, cyc, t} = 0;
		wait_cyc(6);
		chk("running in reset", 12'h000, {11'h000, pwm_running_reg});
		arst_n <= 1'b1;
		wait_cyc(3);
		chk("sinks after reset", 12'h000, current_sink_outputs);
		chk("running after reset", 12'h001, {11'h000, pwm_running_reg});
		// boundary values, one full cycle and into the repeat
		load(V1);
		chk_en = 1'b1;
		wait_cyc(41200);
		for (int c = 0; c < 12; c++) begin
			chk("on clocks", V1[12*c +: 12], 12'(on_cnt[c]));
		end
		// reload mid-cycle, then the off controls
		load(V2);
		wait_cyc(3000);
		ctl(4'b1000, 4);
		ctl(4'b0000, 4);
		ctl(4'b0100, 4);
		ctl(4'b0000, 4);
		ctl(4'b0001, 6);
		ctl(4'b0011, 6);
		ctl(4'b0000, 6);
		// single cycle mode stops after the wrap
		one_shot <= 1'b1;
		load(V1);
		wait_cyc(40950);
		chk_en = 1'b0;
		wait_cyc(30);
		chk("sinks after stop", 12'h000, current_sink_outputs);
		chk("running after stop", 12'h000, {11'h000, pwm_running_reg});
		// a load wakes the stopped sequencer, endless again
		one_shot <= 1'b0;
		load(V2);
		chk_en = 1'b1;
		wait_cyc(300);
		chk("running after reload", 12'h001, {11'h000, pwm_running_reg});
		// reset in mid-run must clear the stored greyscale
		chk_en = 1'b0;
		arst_n <= 1'b0;
		wait_cyc(2);
		chk("running in second reset", 12'h000, {11'h000, pwm_running_reg});
		arst_n <= 1'b1;
		wait_cyc(3);
		chk("sinks after second reset", 12'h000, current_sink_outputs);
		print_verdict();
	end

endmodule
